// [common/counter_array_pkg.sv]
package counter_array_pkg;

   // Register offsets on the plain port (SFR style byte addresses)
   localparam logic [7:0] ADDR_CTRL_FLAGS = 8'hd8;
   localparam logic [7:0] ADDR_MODE_CFG = 8'hd9;
   localparam logic [7:0] ADDR_MODULE_MODE0 = 8'hda;
   localparam logic [7:0] ADDR_CNT_LOW = 8'he9;
   localparam logic [7:0] ADDR_CNT_HIGH = 8'hf9;
   localparam logic [7:0] ADDR_VALUE_LOW0 = 8'hea;
   localparam logic [7:0] ADDR_VALUE_HIGH0 = 8'hfa;
   localparam logic [7:0] ADDR_IDLE_CTRL = 8'hc8;

   // Counter mode register fields
   localparam int MODE_IRQ_EN_BIT = 0;
   localparam int MODE_SRC_LO_BIT = 1;
   localparam int MODE_WDOG_BIT = 6;
   localparam int MODE_IDLE_BIT = 7;
   localparam logic [7:0] MODE_WRITE_MASK = 8'hc7;
   localparam logic [7:0] MODE_RESET = 8'h00;

   // Control flag register fields
   localparam int CTRL_RUN_BIT = 6;
   localparam int CTRL_ROLL_BIT = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Module mode register fields
   localparam int MM_IRQ_BIT = 0;
   localparam int MM_PWM_BIT = 1;
   localparam int MM_TOG_BIT = 2;
   localparam int MM_MAT_BIT = 3;
   localparam int MM_FALL_BIT = 4;
   localparam int MM_RISE_BIT = 5;
   localparam int MM_CMP_BIT = 6;
   localparam logic [7:0] MM_WRITE_MASK = 8'h7f;

   // Prescale divisors
   localparam logic [2:0] DIV_SLOW = 3'h6;
   localparam logic [2:0] DIV_FAST = 3'h2;

   // Count source selection
   typedef enum logic [1:0] {
      SRC_DIV6 = 2'h0,
      SRC_DIV2 = 2'h1,
      SRC_TIMER0 = 2'h2,
      SRC_EXTPIN = 2'h3
   } count_src_e;

   // Plain register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

endpackage

// [hw/edge_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module edge_sync
   import counter_array_pkg::*;
#(
   parameter int WIDTH = 6
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Raw pins and detected edges
   input wire logic [WIDTH-1:0] pinRaw,
   output logic [WIDTH-1:0] pinLevel,
   output logic [WIDTH-1:0] riseEdge,
   output logic [WIDTH-1:0] fallEdge
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] prev_q;

   // Two-stage synchroniser, then one history stage for edges
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= pinRaw;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Each edge seen once because history tracks the synced level
   assign pinLevel = sync_q;
   assign riseEdge = sync_q & ~prev_q;
   assign fallEdge = ~sync_q & prev_q;
endmodule
`default_nettype wire

// [hw/capture_compare_array.sv]
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - One shared free-running 16-bit up counter
// - Source field picks div6, div2, timer0, pin
// - Counter advances only while run bit set
// - Rollover sets sticky flag, software clears
// - Rollover flag raises irq when enabled
// - Module flags set on match or capture
// - All flags share one interrupt request
// - Module mode bit 0 gates its flag into the irq
// - Idle gate bit stops counter during idle
// - Mode bit 6 enables module 4 watchdog
// - Each module owns one port pin
// - Module holds 16-bit capture/compare value
// - Mode bit 6 enables equality comparator
// - Match bit makes match set flag
// - Toggle bit inverts pin on match
// - Falling, rising or both edges capture
// - Pwm bit selects pulse-width output
// - Mode register resets zero, reserved bits zero
// - Capture copies counter into value registers
// - Pwm modules share counter, own duty
// - Toggle output needs compare, match, toggle
module capture_compare_array
   import counter_array_pkg::*;
#(
   parameter int MODULES = 5
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // System status
   input wire logic cpuIdle,
   input wire logic timer0Overflow,
   // Port pins: external count pin and module pins
   input wire logic external_count_pin,
   input wire logic [MODULES-1:0] modulePinIn,
   output logic [MODULES-1:0] modulePinOut,
   // Interrupt and watchdog reset request
   output logic irqReq,
   output logic wdogResetReq
);
   reg_req_s req;
   logic [7:0] modeCfg_q;
   logic [7:0] ctrlFlags_q;
   logic [15:0] count_q;
   logic [2:0] prescale_q;
   logic [7:0] moduleMode_q [MODULES];
   logic [15:0] moduleValue_q [MODULES];
   logic [MODULES-1:0] pinOut_q;
   logic irq_q;
   logic wdog_q;
   logic [7:0] rdata_q;
   logic [MODULES:0] pinLevel;
   logic [MODULES:0] riseEdge;
   logic [MODULES:0] fallEdge;
   logic tick;
   logic advance;
   logic [MODULES-1:0] hit;
   logic [MODULES-1:0] capture;
   logic [MODULES-1:0] event_;
   logic prescaleWrap;
   logic [2:0] divisor;
   count_src_e src;

   assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
   assign src = count_src_e'(modeCfg_q[MODE_SRC_LO_BIT +: 2]);

   // Capture pins and the count pin share one synchroniser bank
   edge_sync #(
      .WIDTH(MODULES + 1)
   ) u_sync (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .pinRaw({external_count_pin, modulePinIn}),
      .pinLevel(pinLevel),
      .riseEdge(riseEdge),
      .fallEdge(fallEdge)
   );

   // Prescaler runs on every clock whatever source is chosen; the source only picks the divisor
   assign divisor = (src == SRC_DIV6) ? DIV_SLOW : DIV_FAST;
   assign prescaleWrap = (prescale_q == divisor - 3'h1);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         prescale_q <= 3'h0;
      end else if (prescaleWrap) begin
         prescale_q <= 3'h0;
      end else begin
         prescale_q <= prescale_q + 3'h1;
      end
   end

   // Count pulse selection; pin rate limit is on the driver side
   always_comb begin
      case (src)
         SRC_DIV6: tick = prescaleWrap;
         SRC_DIV2: tick = prescaleWrap;
         SRC_TIMER0: tick = timer0Overflow;
         SRC_EXTPIN: tick = fallEdge[MODULES];
         default: tick = 1'b0;
      endcase
   end

   // Run bit and idle gate both hold the counter
   assign advance = tick && ctrlFlags_q[CTRL_RUN_BIT]
      && !(modeCfg_q[MODE_IDLE_BIT] && cpuIdle);

   // Shared time base; software may also load it
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         count_q <= 16'h0000;
      end else if (req.wr && req.addr == ADDR_CNT_LOW) begin
         count_q[7:0] <= req.wdata;
      end else if (req.wr && req.addr == ADDR_CNT_HIGH) begin
         count_q[15:8] <= req.wdata;
      end else if (advance) begin
         count_q <= count_q + 16'h0001;
      end
   end

   // Per-module compare, capture, pin and value logic
   for (genvar m = 0; m < MODULES; m++) begin : g_mod
      logic [7:0] mm;
      assign mm = moduleMode_q[m];
      assign hit[m] = mm[MM_CMP_BIT]
         && (count_q == moduleValue_q[m]);
      assign capture[m] = (mm[MM_RISE_BIT] && riseEdge[m])
         || (mm[MM_FALL_BIT] && fallEdge[m]);
      assign event_[m] = capture[m] || (hit[m] && mm[MM_MAT_BIT]);

      // Mode register; reserved bit 7 never stores
      always_ff @(posedge mclk or posedge sys_rst) begin
         if (sys_rst) begin
            moduleMode_q[m] <= 8'h00;
         end else if (req.wr && req.addr == ADDR_MODULE_MODE0 + 8'(m)) begin
            moduleMode_q[m] <= req.wdata & MM_WRITE_MASK;
         end
      end

      // Value register; hardware capture wins over a same-cycle write
      always_ff @(posedge mclk or posedge sys_rst) begin
         if (sys_rst) begin
            moduleValue_q[m] <= 16'h0000;
         end else if (capture[m]) begin
            moduleValue_q[m] <= count_q;
         end else if (req.wr && req.addr == ADDR_VALUE_LOW0 + 8'(m)) begin
            moduleValue_q[m][7:0] <= req.wdata;
         end else if (req.wr && req.addr == ADDR_VALUE_HIGH0 + 8'(m)) begin
            moduleValue_q[m][15:8] <= req.wdata;
         end
      end

      // Pin drive: pwm compares low bytes, else toggle on match
      always_ff @(posedge mclk or posedge sys_rst) begin
         if (sys_rst) begin
            pinOut_q[m] <= 1'b1;
         end else if (mm[MM_PWM_BIT] && mm[MM_CMP_BIT]) begin
            pinOut_q[m] <= !(count_q[7:0]
               < moduleValue_q[m][7:0]);
         end else if (hit[m] && mm[MM_TOG_BIT] && mm[MM_MAT_BIT]
            && advance) begin
            pinOut_q[m] <= ~pinOut_q[m];
         end
      end
   end

   // Module n sits on port bit 1.(3+n); pin order follows module index
   assign modulePinOut = pinOut_q;

   // Mode register; reserved bits 5..3 forced to zero
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         modeCfg_q <= MODE_RESET;
      end else if (req.wr && req.addr == ADDR_MODE_CFG) begin
         modeCfg_q <= req.wdata & MODE_WRITE_MASK;
      end
   end

   // Flags: hardware set wins over a software clear in the same cycle
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrlFlags_q <= CTRL_RESET;
      end else begin
         if (req.wr && req.addr == ADDR_CTRL_FLAGS) begin
            ctrlFlags_q <= {req.wdata[7:6], 1'b0, req.wdata[4:0]};
         end
         if (advance && count_q == 16'hffff) begin
            ctrlFlags_q[CTRL_ROLL_BIT] <= 1'b1;
         end
         for (int i = 0; i < MODULES; i++) begin
            if (event_[i]) begin
               ctrlFlags_q[i] <= 1'b1;
            end
         end
      end
   end

   // One shared request from all gated flags
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= (ctrlFlags_q[CTRL_ROLL_BIT] && modeCfg_q[MODE_IRQ_EN_BIT])
            || |(ctrlFlags_q[MODULES-1:0] & irqMask());
      end
   end

   function automatic logic [MODULES-1:0] irqMask();
      logic [MODULES-1:0] r;
      r = '0;
      for (int i = 0; i < MODULES; i++) begin
         r[i] = moduleMode_q[i][MM_IRQ_BIT];
      end
      return r;
   endfunction

   // Watchdog on the last module: a hit with match set asks for reset
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wdog_q <= 1'b0;
      end else begin
         wdog_q <= modeCfg_q[MODE_WDOG_BIT] && hit[MODULES-1]
            && moduleMode_q[MODULES-1][MM_MAT_BIT] && advance;
      end
   end

   // Read port; unmapped addresses return zero
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= 8'h00;
      end else if (req.rd) begin
         rdata_q <= 8'h00;
         if (req.addr == ADDR_CTRL_FLAGS) rdata_q <= ctrlFlags_q;
         if (req.addr == ADDR_MODE_CFG) rdata_q <= modeCfg_q;
         if (req.addr == ADDR_CNT_LOW) rdata_q <= count_q[7:0];
         if (req.addr == ADDR_CNT_HIGH) rdata_q <= count_q[15:8];
         for (int i = 0; i < MODULES; i++) begin
            if (req.addr == ADDR_MODULE_MODE0 + 8'(i)) rdata_q <= moduleMode_q[i];
            if (req.addr == ADDR_VALUE_LOW0 + 8'(i)) rdata_q <= moduleValue_q[i][7:0];
            if (req.addr == ADDR_VALUE_HIGH0 + 8'(i)) rdata_q <= moduleValue_q[i][15:8];
         end
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign regRdata = rdata_q;
   assign irqReq = irq_q;
   assign wdogResetReq = wdog_q;

   // Rollover flag follows a wrapping advance within one cycle
   chk_rollover_sets: assert property (@(posedge mclk) disable iff (sys_rst)
      advance && count_q == 16'hffff |=> ctrlFlags_q[CTRL_ROLL_BIT])
      else $error("rollover flag not set");
   chk_count_holds: assert property (@(posedge mclk) disable iff (sys_rst)
      !ctrlFlags_q[CTRL_RUN_BIT] && !(req.wr) |=> $stable(count_q))
      else $error("counter moved while stopped");
   chk_idle_gate: assert property (@(posedge mclk) disable iff (sys_rst)
      modeCfg_q[MODE_IDLE_BIT] && cpuIdle && !req.wr |=> $stable(count_q))
      else $error("counter ran in idle");
   chk_capture_value: assert property (@(posedge mclk) disable iff (sys_rst)
      capture[0] |=> moduleValue_q[0] == $past(count_q))
      else $error("capture value wrong");
   chk_event_flag: assert property (@(posedge mclk) disable iff (sys_rst)
      event_[1] |=> ctrlFlags_q[1])
      else $error("module flag not set");
   chk_irq_gate: assert property (@(posedge mclk) disable iff (sys_rst)
      ctrlFlags_q[CTRL_ROLL_BIT] && modeCfg_q[MODE_IRQ_EN_BIT] |=> irqReq)
      else $error("overflow irq missing");
   chk_irq_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
      ctrlFlags_q == 8'h00 |=> !irqReq)
      else $error("irq without flag");
   chk_mode_reserved: assert property (@(posedge mclk) disable iff (sys_rst)
      modeCfg_q[5:3] == 3'h0)
      else $error("reserved mode bits set");
endmodule
`default_nettype wire

// [tb/pin_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
   // Clock
   input wire logic mclk,
   // Port pins toward the array
   output logic extPin,
   output logic [4:0] capPins
);
   // Pins rest high, as pulled-up port lines do
   initial begin
      extPin = 1'b1;
      capPins = 5'h1f;
   end
   // Eight clocks a half period, far below the quarter-rate ceiling
   task automatic countEdges(input int n);
      repeat (n) begin
         repeat (8) @(posedge mclk);
         extPin <= 1'b0;
         repeat (8) @(posedge mclk);
         extPin <= 1'b1;
      end
   endtask
   // Move one capture pin and hold it there
   task automatic setPin(input int idx, input logic lvl);
      @(posedge mclk);
      capPins[idx] <= lvl;
   endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import counter_array_pkg::*;
   logic mclk, sysRst, regWr, regRd, cpuIdle, t0, extPin, irq, wdReq;
   logic [7:0] regAddr, regWdata, regRdata, v;
   logic [4:0] capPins, pinOut;
   logic wdSeen;
   int miscompares, checksDone, cycles;

   capture_compare_array dut (.mclk(mclk), .sys_rst(sysRst),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .cpuIdle(cpuIdle),
      .timer0Overflow(t0), .external_count_pin(extPin),
      .modulePinIn(capPins), .modulePinOut(pinOut), .irqReq(irq),
      .wdogResetReq(wdReq));
   pin_partner pp (.mclk(mclk), .extPin(extPin), .capPins(capPins));

   // 50 MHz clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // Watchdog request is a one-cycle pulse, so latch it
   always @(posedge mclk) begin
      if (wdReq === 1'b1) wdSeen <= 1'b1;
   end
   // Hang guard, well above the expected run length
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checksDone, miscompares);
      if (miscompares == 0 && checksDone > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checksDone++;
      if (e !== g) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Loose compare where the prescaler phase is free
   task automatic near(input string n, input int e, input logic [7:0] g);
      chk(n, 8'h1, {7'h0, g >= e - 2 && g <= e + 2});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic setCount(input logic [15:0] c);
      wr(ADDR_CNT_LOW, c[7:0]);
      wr(ADDR_CNT_HIGH, c[15:8]);
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge mclk);
         t0 <= 1'b1;
         @(posedge mclk);
         t0 <= 1'b0;
      end
      waitc(4);
   endtask
   // Run the counter for a fixed span on a clock source
   task automatic span(input logic [7:0] mode);
      setCount(16'h0000);
      wr(ADDR_MODE_CFG, mode);
      wr(ADDR_CTRL_FLAGS, 8'h40);
      waitc(60);
      wr(ADDR_CTRL_FLAGS, 8'h00);
      rd(ADDR_CNT_LOW, v);
   endtask

   // Main sequence
   initial begin
      sysRst = 1'b1;
      regAddr = 8'h00;
      regWdata = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      cpuIdle = 1'b0;
      t0 = 1'b0;
      wdSeen = 1'b0;
      waitc(5);
      sysRst <= 1'b0;
      rd(ADDR_MODE_CFG, v);
      chk("mode", MODE_RESET, v);
      rd(ADDR_CTRL_FLAGS, v);
      chk("ctrl", CTRL_RESET, v);
      chk("pins", 8'h1f, {3'h0, pinOut});
      wr(ADDR_MODE_CFG, 8'hff);
      rd(ADDR_MODE_CFG, v);
      chk("mask", MODE_WRITE_MASK, v);
      rd(8'h00, v);
      chk("unmapped", 8'h00, v);
      span(8'h00);
      near("div6", 62 / DIV_SLOW, v);
      span(8'h02);
      near("div2", 62 / DIV_FAST, v);
      cpuIdle <= 1'b1;
      span(8'h82);
      chk("idle", 8'h00, v);
      cpuIdle <= 1'b0;
      // Timer0 source, counter left running from here on
      wr(ADDR_MODE_CFG, 8'h04);
      wr(ADDR_CTRL_FLAGS, 8'h40);
      pulse(7);
      rd(ADDR_CNT_LOW, v);
      chk("t0", 8'h07, v);
      wr(ADDR_MODE_CFG, 8'h06);
      setCount(16'h0000);
      pp.countEdges(5);
      waitc(4);
      rd(ADDR_CNT_LOW, v);
      chk("ext", 8'h05, v);
      // Rollover raises a sticky flag and the shared request
      wr(ADDR_MODE_CFG, 8'h05);
      setCount(16'hffff);
      pulse(1);
      rd(ADDR_CNT_HIGH, v);
      chk("wrap", 8'h00, v);
      rd(ADDR_CTRL_FLAGS, v);
      chk("cf", 8'hc0, v);
      chk("irq", 8'h01, {7'h0, irq});
      wr(ADDR_CTRL_FLAGS, 8'h40);
      waitc(2);
      chk("irqoff", 8'h00, {7'h0, irq});
      // Module 0 rising only, interrupt enabled
      wr(ADDR_MODULE_MODE0, 8'h21);
      setCount(16'h1234);
      pp.setPin(0, 1'b0);
      waitc(6);
      rd(ADDR_VALUE_LOW0, v);
      chk("nofall", 8'h00, v);
      pp.setPin(0, 1'b1);
      waitc(6);
      rd(ADDR_VALUE_LOW0, v);
      chk("caplo", 8'h34, v);
      rd(ADDR_VALUE_HIGH0, v);
      chk("caphi", 8'h12, v);
      rd(ADDR_CTRL_FLAGS, v);
      chk("ccf0", 8'h41, v);
      chk("irq0", 8'h01, {7'h0, irq});
      wr(ADDR_CTRL_FLAGS, 8'h40);
      // Module 1 both edges, interrupt masked
      wr(ADDR_MODULE_MODE0 + 8'h01, 8'h30);
      setCount(16'h0abc);
      pp.setPin(1, 1'b0);
      waitc(6);
      rd(ADDR_VALUE_LOW0 + 8'h01, v);
      chk("fall1", 8'hbc, v);
      chk("mask1", 8'h00, {7'h0, irq});
      setCount(16'h0abd);
      pp.setPin(1, 1'b1);
      waitc(6);
      rd(ADDR_VALUE_LOW0 + 8'h01, v);
      chk("rise1", 8'hbd, v);
      wr(ADDR_CTRL_FLAGS, 8'h40);
      // Module 2 high-speed output at count 3
      wr(ADDR_MODULE_MODE0 + 8'h02, 8'h4c);
      wr(ADDR_VALUE_LOW0 + 8'h02, 8'h03);
      setCount(16'h0000);
      pulse(4);
      chk("tog", 8'h00, {7'h0, pinOut[2]});
      rd(ADDR_CTRL_FLAGS, v);
      chk("ccf2", 8'h44, v);
      // Module 3 pulse width, duty 0x80
      wr(ADDR_MODULE_MODE0 + 8'h03, 8'h42);
      wr(ADDR_VALUE_LOW0 + 8'h03, 8'h80);
      setCount(16'h0010);
      pulse(1);
      chk("pwmlo", 8'h00, {7'h0, pinOut[3]});
      setCount(16'h0090);
      pulse(1);
      chk("pwmhi", 8'h01, {7'h0, pinOut[3]});
      // Module 4 watchdog match at count 5
      wr(ADDR_MODE_CFG, 8'h44);
      wr(ADDR_MODULE_MODE0 + 8'h04, 8'h48);
      wr(ADDR_VALUE_LOW0 + 8'h04, 8'h05);
      setCount(16'h0004);
      pulse(2);
      chk("wdog", 8'h01, {7'h0, wdSeen});
      tally_and_finish();
   end
endmodule
`default_nettype wire
